// >>> shared/sdrt_pkg.sv
package sdrt_pkg;
  // clock period at 10 MHz
  localparam int unsigned CLK_PERIOD_PS = 100000;
  // termination reference points in actual clock cycles
  localparam int unsigned TERM_ON_CYCLES = 2;
  localparam int unsigned TERM_OFF_EDGES = 2;
  // write to read, clock enable width, power-down exit, in clock cycles
  localparam logic [7:0] WTR_CYCLES = 8'h02;
  localparam logic [7:0] CKE_MIN_CYCLES = 8'h03;
  localparam logic [7:0] PDX_CYCLES = 8'h03;
  // time-based parameters in ps, with derived cycle counts rounded up
  localparam int unsigned PRECHARGE_PS = 13125;
  localparam int unsigned RAS_MIN_PS = 45000;
  localparam int unsigned RTP_PS = 7500;
  localparam logic [7:0] PRECHARGE_CYC = 8'((PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RAS_MIN_CYC = 8'((RAS_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RTP_CYC = 8'((RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // reset values of mode settings
  localparam logic [7:0] WR_RESET = 8'h08;
  localparam logic [7:0] AL_RESET = 8'h00;
  localparam logic [7:0] BL_RESET = 8'h04;
  localparam int unsigned STROBE_BIT = 10;
  localparam int unsigned NBANK = 8;
  // command encodings
  typedef enum logic [2:0] {
    SDRT_NOP = 3'h0, SDRT_ACT = 3'h1, SDRT_RD = 3'h2, SDRT_WR = 3'h3,
    SDRT_PRE = 3'h4, SDRT_WRA = 3'h5, SDRT_MRS = 3'h6
  } sdrt_cmd_t;
endpackage

// >>> shared/sdrt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sdrt_if;
  logic               cke;
  logic               odt;
  sdrt_pkg::sdrt_cmd_t cmd;
  logic [2:0]         bank;
  logic [12:0]        mode;
  logic               term_on;
  logic               strobe_diff;
  modport ctrl (output cke, output odt, output cmd, output bank, output mode,
                input term_on, input strobe_diff);
  modport mem  (input cke, input odt, input cmd, input bank, input mode,
                output term_on, output strobe_diff);
endinterface
`default_nettype wire

// >>> rtl/sdrt_mem_end.sv
`timescale 1ns/1ns
`default_nettype none
module sdrt_mem_end (
  input  wire logic clk,
  input  wire logic rst_b,
  sdrt_if.mem       link,
  output logic      cke_seen,
  output logic      wr_seen
);
  logic [1:0] on_cnt;
  logic [1:0] off_cnt;
  logic       odt_q;

  // odt edge tracking; reference points counted in real clock edges
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      odt_q <= 1'b0;
      on_cnt <= 2'h0;
      off_cnt <= 2'h0;
      link.term_on <= 1'b0;
    end else begin
      odt_q <= link.odt;
      if (link.odt && !odt_q) begin
        on_cnt <= 2'(sdrt_pkg::TERM_ON_CYCLES - 1);
      end else if (on_cnt != 2'h0) begin
        on_cnt <= on_cnt - 2'h1;
      end
      if (!link.odt && odt_q) begin
        off_cnt <= 2'(sdrt_pkg::TERM_OFF_EDGES);
      end else if (off_cnt != 2'h0) begin
        off_cnt <= off_cnt - 2'h1;
      end
      if (on_cnt == 2'h1) begin
        link.term_on <= 1'b1; // RULE2
      end else if (off_cnt == 2'h1) begin
        link.term_on <= 1'b0; // RULE3
      end
    end
  end

  // strobe mode from mode register bit, differential when zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.strobe_diff <= 1'b1;
    end else if (link.cmd == sdrt_pkg::SDRT_MRS) begin
      link.strobe_diff <= ~link.mode[sdrt_pkg::STROBE_BIT]; // RULE10
    end
  end

  // observed state for the user side
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cke_seen <= 1'b0;
      wr_seen <= 1'b0;
    end else begin
      cke_seen <= link.cke;
      wr_seen <= (link.cmd == sdrt_pkg::SDRT_WR) || (link.cmd == sdrt_pkg::SDRT_WRA);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sdrt_ctrl_end.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE1 - clock changes only in self-refresh or power-down
// RULE2 - termination on two cycles after odt high
// RULE3 - termination off half period after second edge; code drops it at the third edge after odt falls
// RULE4 - write to read at least two cycles
// RULE5 - clock enable held three registered edges
// RULE6 - rewrite location after bad write timing
// RULE7 - time parameters rounded up to cycles
// RULE8 - autoprecharge recovery equals write recovery plus precharge
// RULE9 - activate three edges after power-down exit
// RULE10 - strobe differential when mode bit ten zero
// RULE11 - read to precharge at least al plus bl/2
// RULE12 - per-bank down-counters gate constrained commands
module sdrt_ctrl_end (
  input  wire logic                clk,
  input  wire logic                rst_b,
  sdrt_if.ctrl                     link,
  input  wire logic                req_valid,
  input  wire sdrt_pkg::sdrt_cmd_t req_cmd,
  input  wire logic [2:0]          req_bank,
  input  wire logic [12:0]         req_mode,
  input  wire logic                req_odt,
  input  wire logic                req_cke,
  input  wire logic                wr_bad,
  input  wire logic                freq_change_req,
  output logic                     req_ready,
  output logic                     freq_change_ok,
  output logic                     rewrite_needed,
  output logic [7:0]               dal_cycles
);
  logic [7:0] wr_rec;
  logic [7:0] add_lat;
  logic [7:0] burst;
  logic [7:0] wtr_cnt;
  logic [7:0] cke_cnt;
  logic [7:0] pdx_cnt;
  logic [7:0] pre_cnt [sdrt_pkg::NBANK];
  logic [7:0] act_cnt [sdrt_pkg::NBANK];
  logic       issue;
  logic       allowed;
  logic       cke_change;
  logic       cke_take;
  logic [7:0] rd_pre;

  // read to precharge spacing, never shorter than rtp
  assign rd_pre = (add_lat + (burst >> 1)) > sdrt_pkg::RTP_CYC ?
                  add_lat + (burst >> 1) : sdrt_pkg::RTP_CYC; // RULE11
  assign cke_change = req_valid && (req_cke != link.cke);
  // a clock enable change goes out alone with nop on the command pins, so no
  // command shares the edge that registers power-down entry or exit
  assign cke_take = cke_change && (cke_cnt == 8'h00); // RULE5

  // gate each command on its timers
  always_comb begin
    allowed = 1'b1;
    unique case (req_cmd)
      sdrt_pkg::SDRT_RD: allowed = (wtr_cnt == 8'h00); // RULE4
      sdrt_pkg::SDRT_ACT: allowed = (pdx_cnt == 8'h00) && (pre_cnt[req_bank] == 8'h00); // RULE9
      sdrt_pkg::SDRT_PRE: allowed = (pre_cnt[req_bank] == 8'h00) && (act_cnt[req_bank] == 8'h00); // RULE12
      default: allowed = 1'b1;
    endcase
    if (cke_change) begin
      allowed = 1'b0; // RULE9
    end
  end
  assign issue = req_valid && allowed;

  // drive command pins, one command per cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.cmd <= sdrt_pkg::SDRT_NOP;
      link.bank <= 3'h0;
      link.mode <= 13'h0000;
      link.odt <= 1'b0;
      link.cke <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= allowed;
      link.cmd <= issue ? req_cmd : sdrt_pkg::SDRT_NOP;
      link.bank <= req_bank;
      link.mode <= req_mode;
      link.odt <= req_odt;
      if (cke_take) begin
        link.cke <= req_cke; // RULE5
      end
    end
  end

  // mode settings captured from mode register writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_rec <= sdrt_pkg::WR_RESET;
      add_lat <= sdrt_pkg::AL_RESET;
      burst <= sdrt_pkg::BL_RESET;
    end else if (issue && req_cmd == sdrt_pkg::SDRT_MRS) begin
      wr_rec <= 8'(req_mode[11:9]) + 8'h01;
      add_lat <= 8'(req_mode[5:3]);
      burst <= req_mode[2:0] == 3'h3 ? 8'h08 : 8'h04;
    end
  end

  // global timers: write-to-read, clock enable width, power-down exit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wtr_cnt <= 8'h00;
      cke_cnt <= 8'h00;
      pdx_cnt <= 8'h00;
    end else begin
      if (issue && req_cmd inside {sdrt_pkg::SDRT_WR, sdrt_pkg::SDRT_WRA}) begin
        wtr_cnt <= sdrt_pkg::WTR_CYCLES; // RULE4
      end else if (wtr_cnt != 8'h00) begin
        wtr_cnt <= wtr_cnt - 8'h01;
      end
      if (cke_take) begin
        cke_cnt <= sdrt_pkg::CKE_MIN_CYCLES; // RULE5
      end else if (cke_cnt != 8'h00) begin
        cke_cnt <= cke_cnt - 8'h01;
      end
      if (cke_take && req_cke) begin
        pdx_cnt <= sdrt_pkg::PDX_CYCLES; // RULE9
      end else if (pdx_cnt != 8'h00) begin
        pdx_cnt <= pdx_cnt - 8'h01;
      end
    end
  end

  // per-bank down-counters, counting real clock edges
  for (genvar b = 0; b < sdrt_pkg::NBANK; b++) begin : g_bank
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        pre_cnt[b] <= 8'h00;
        act_cnt[b] <= 8'h00;
      end else begin
        if (issue && req_bank == 3'(b) && req_cmd == sdrt_pkg::SDRT_WRA) begin
          pre_cnt[b] <= wr_rec + sdrt_pkg::PRECHARGE_CYC; // RULE8
        end else if (issue && req_bank == 3'(b) && req_cmd == sdrt_pkg::SDRT_PRE) begin
          pre_cnt[b] <= sdrt_pkg::PRECHARGE_CYC; // RULE7
        end else if (issue && req_bank == 3'(b) && req_cmd == sdrt_pkg::SDRT_RD) begin
          pre_cnt[b] <= rd_pre; // RULE11
        end else if (pre_cnt[b] != 8'h00) begin
          pre_cnt[b] <= pre_cnt[b] - 8'h01; // RULE12
        end
        if (issue && req_bank == 3'(b) && req_cmd == sdrt_pkg::SDRT_ACT) begin
          act_cnt[b] <= sdrt_pkg::RAS_MIN_CYC; // RULE7
        end else if (act_cnt[b] != 8'h00) begin
          act_cnt[b] <= act_cnt[b] - 8'h01;
        end
      end
    end
  end

  // status: frequency change only with cke low, rewrite flag, dal
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freq_change_ok <= 1'b0;
      rewrite_needed <= 1'b0;
      dal_cycles <= 8'h00;
    end else begin
      freq_change_ok <= freq_change_req && !link.cke && (cke_cnt == 8'h00); // RULE1
      if (wr_bad) begin
        rewrite_needed <= 1'b1; // RULE6
      end else if (issue && req_cmd == sdrt_pkg::SDRT_WR) begin
        rewrite_needed <= 1'b0;
      end
      dal_cycles <= wr_rec + sdrt_pkg::PRECHARGE_CYC; // RULE8
    end
  end
endmodule
`default_nettype wire

// >>> testbench/sdrt_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sdrt_monitor (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                cke,
  input wire logic                odt,
  input wire sdrt_pkg::sdrt_cmd_t cmd,
  input wire logic [2:0]          bank,
  input wire logic [12:0]         mode,
  input wire logic                term_on,
  input wire logic                strobe_diff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // local copies keep the check tied to the bank or bit seen with the command
  property p_rd_pre;
    logic [2:0] b;
    (cmd == sdrt_pkg::SDRT_RD, b = bank) |=> !(cmd == sdrt_pkg::SDRT_PRE && bank == b);
  endproperty
  property p_strobe;
    logic s;
    (cmd == sdrt_pkg::SDRT_MRS, s = mode[sdrt_pkg::STROBE_BIT]) |=> strobe_diff == !s;
  endproperty
  a_term_on_delay: assert property ($rose(odt) && !term_on |=> !term_on ##1 term_on)
    else $error("termination on at wrong edge");
  a_term_off_delay: assert property ($fell(odt) && term_on |=> term_on [*2] ##1 !term_on)
    else $error("termination off at wrong edge");
  a_write_read_gap: assert property (cmd == sdrt_pkg::SDRT_WR |=> cmd != sdrt_pkg::SDRT_RD)
    else $error("read too soon after write");
  a_cke_width_held: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("clock enable toggled too soon");
  a_exit_act_gap: assert property ($rose(cke) |-> (cmd != sdrt_pkg::SDRT_ACT) [*3])
    else $error("activate too soon after exit");
  a_read_pre_gap: assert property (p_rd_pre)
    else $error("precharge too soon after read");
  a_strobe_mode: assert property (p_strobe)
    else $error("strobe mode not taken");
  a_strobe_reset: assert property ($rose(rst_b) |-> strobe_diff)
    else $error("strobe mode wrong after reset");
  // main traffic shapes
  c_wr_rd: cover property (cmd == sdrt_pkg::SDRT_WR ##[1:6] cmd == sdrt_pkg::SDRT_RD);
  c_exit: cover property ($rose(cke));
  c_off: cover property ($fell(odt));
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module tb;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                req_valid = 1'b0;
  logic                req_odt = 1'b0;
  logic                req_cke = 1'b0;
  logic                wr_bad = 1'b0;
  logic                freq_change_req = 1'b0;
  sdrt_pkg::sdrt_cmd_t req_cmd = sdrt_pkg::SDRT_NOP;
  logic [2:0]          req_bank = 3'h0;
  logic [12:0]         req_mode = 13'h0000;
  logic                req_ready, freq_change_ok, rewrite_needed, cke_seen, wr_seen;
  logic [7:0]          dal_cycles;
  int                  errors = 0, n_compared = 0, cyc = 0, t_wr = 0, t_exit = 0;
  sdrt_if link ();
  sdrt_ctrl_end i_sdrt_ctrl_end (.clk(clk), .rst_b(rst_b), .link(link.ctrl),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_mode(req_mode),
    .req_odt(req_odt), .req_cke(req_cke), .wr_bad(wr_bad), .freq_change_req(freq_change_req),
    .req_ready(req_ready), .freq_change_ok(freq_change_ok),
    .rewrite_needed(rewrite_needed), .dal_cycles(dal_cycles));
  sdrt_mem_end i_sdrt_mem_end (.clk(clk), .rst_b(rst_b), .link(link.mem),
    .cke_seen(cke_seen), .wr_seen(wr_seen));
  sdrt_monitor i_sdrt_monitor (.clk(clk), .rst_b(rst_b), .cke(link.cke), .odt(link.odt),
    .cmd(link.cmd), .bank(link.bank), .mode(link.mode), .term_on(link.term_on),
    .strobe_diff(link.strobe_diff));
  // 100 ns clock and a cycle count for gap checks
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // one-cycle request pulses; a refused one is simply retried
  task automatic issue(input sdrt_pkg::sdrt_cmd_t c, input logic [2:0] b, input logic [12:0] m);
    repeat (40) begin
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_bank <= b;
      req_mode <= m;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      if (link.cmd === c) return;
    end
    `CHK("issued command", c, link.cmd)
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog well beyond the sixty or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    `CHK("watchdog", 1'b0, 1'b1)
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    req_cke <= 1'b1;
    req_odt <= 1'b1;
    #1;
    `CHK("strobe_diff", 1'b1, link.strobe_diff)
    issue(sdrt_pkg::SDRT_MRS, 3'h0, 13'h0200);
    repeat (4) @(posedge clk);
    #1;
    `CHK("term_on", 1'b1, link.term_on)
    `CHK("dal", 8'h02 + sdrt_pkg::PRECHARGE_CYC, dal_cycles)
    `CHK("cke_seen", 1'b1, cke_seen)
    $display("power up test done");
    issue(sdrt_pkg::SDRT_ACT, 3'h0, 13'h0000);
    issue(sdrt_pkg::SDRT_WR, 3'h0, 13'h0000);
    t_wr = cyc;
    issue(sdrt_pkg::SDRT_RD, 3'h0, 13'h0000);
    `CHK("wtr gap", 1'b1, 1'((cyc - t_wr) >= 2))
    `CHK("req_ready", 1'b1, req_ready)
    issue(sdrt_pkg::SDRT_PRE, 3'h0, 13'h0000);
    @(posedge clk);
    wr_bad <= 1'b1;
    @(posedge clk);
    wr_bad <= 1'b0;
    #1;
    `CHK("rewrite_needed", 1'b1, rewrite_needed)
    // the rewrite of the damaged location clears the flag
    issue(sdrt_pkg::SDRT_WR, 3'h0, 13'h0000);
    `CHK("rewrite_needed", 1'b0, rewrite_needed)
    @(posedge clk);
    #1;
    `CHK("wr_seen", 1'b1, wr_seen)
    issue(sdrt_pkg::SDRT_MRS, 3'h0, 13'h0400);
    repeat (3) @(posedge clk);
    // drop into power-down, ask for a clock change, then exit into activate
    req_cke <= 1'b0;
    req_odt <= 1'b0;
    #1;
    `CHK("strobe_diff", 1'b0, link.strobe_diff)
    `CHK("dal", 8'h03 + sdrt_pkg::PRECHARGE_CYC, dal_cycles)
    $display("access test done");
    issue(sdrt_pkg::SDRT_PRE, 3'h1, 13'h0000);
    @(posedge clk);
    freq_change_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("freq_change_ok", 1'b1, freq_change_ok)
    `CHK("term_on", 1'b0, link.term_on)
    // exit is asked one edge on; activate needs three registered edges of cke high
    @(posedge clk);
    freq_change_req <= 1'b0;
    req_cke <= 1'b1;
    t_exit = cyc;
    issue(sdrt_pkg::SDRT_ACT, 3'h1, 13'h0000);
    `CHK("exit to activate", 1'b1, 1'((cyc - t_exit) >= 6))
    $display("power down test done");
    results();
  end
endmodule
`default_nettype wire
